// File: rtl/ifs_map.vh
// constants for the indirect fifo size register bank
// assumes it is included by bare name from the rtl/ design files
// Function
// - each window access advances pointer one quadlet
// - pointer is 16-bit read/write at 0x0f8
// - window moves full quadlet at pointer location
// - 0x100-0x1fc decode sizes, rest reserved
// - size registers reachable only through pointer/window
// - capacity is (last-first+1) times 64 quadlets
// - fifos share memory, block index in bits 11:6
// - first index bits 13:8, last 5:0
// - bits 31:14 and 7:6 read zero
// - rx response size at 0x100, blocks 0-3
// - rx request size at 0x104, blocks 4-7
// - tx response size at 0x110, blocks 8-11
// - tx request size at 0x114, blocks 12-15
// - iso receive size at 0x120, blocks 16-31
// - iso transmit size at 0x130, blocks 32-47
// - select line low steers to shadow register
`ifndef IFS_MAP_VH
`define IFS_MAP_VH

// --------------------------------------------------------------
// direct host register offsets
// --------------------------------------------------------------
`define IFS_HOST_AW          8
`define IFS_DIR_POINTER      8'hf8
`define IFS_DIR_WINDOW       8'hfc

// --------------------------------------------------------------
// indirect space
// --------------------------------------------------------------
`define IFS_PTR_W            16
`define IFS_QUADLET_STEP     16'h0004
`define IFS_SIZE_LO          16'h0100
`define IFS_SIZE_HI          16'h01fc
`define IFS_OFS_RX_RSP       16'h0100
`define IFS_OFS_RX_REQ       16'h0104
`define IFS_OFS_TX_RSP       16'h0110
`define IFS_OFS_TX_REQ       16'h0114
`define IFS_OFS_ISO_RX       16'h0120
`define IFS_OFS_ISO_TX       16'h0130

// --------------------------------------------------------------
// size register layout and reset values
// --------------------------------------------------------------
`define IFS_NUM_FIFOS        6
`define IFS_IDX_W            6
`define IFS_FIRST_MSB        13
`define IFS_FIRST_LSB        8
`define IFS_LAST_MSB         5
`define IFS_LAST_LSB         0
`define IFS_BLOCK_LOW_ZERO   6'h00
`define IFS_BLOCK_LOW_ONES   6'h3f
`define IFS_MEM_AW           12
`define IFS_SIZE_W           13
`define IFS_RST_RX_RSP       32'h00000003
`define IFS_RST_RX_REQ       32'h00000407
`define IFS_RST_TX_RSP       32'h0000080b
`define IFS_RST_TX_REQ       32'h00000c0f
`define IFS_RST_ISO_RX       32'h0000101f
`define IFS_RST_ISO_TX       32'h0000202f

// --------------------------------------------------------------
// shadow register
// --------------------------------------------------------------
`define IFS_SHADOW_RESET     32'h0f0a0500

`endif

// File: rtl/ifs_sync.v
// two-flop synchroniser for a bundle of host pins
// assumes the bundle is held stable by the host while it matters
`timescale 1ns/1ps
module ifs_sync #(
    parameter W = 8
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst_n,
    // pins in, synchronised out
    input  wire [W-1:0] pin_in,
    input  wire [W-1:0] rst_val,
    output reg  [W-1:0] pin_sync
);

    reg [W-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge mclk) begin
        if (!rst_n) begin
            meta_r   <= rst_val;
            pin_sync <= rst_val;
        end else begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end

endmodule

// File: rtl/ifs_size_bank.v
// six fifo size registers of the indirect space, with decoded layout
// assumes the caller gates writes to window accesses only
`timescale 1ns/1ps
`include "ifs_map.vh"
module ifs_size_bank #(
    parameter NUM = `IFS_NUM_FIFOS
) (
    // clock and reset
    input  wire                         mclk,
    input  wire                         rst_n,
    // indirect access
    input  wire [`IFS_PTR_W-1:0]        ptr,
    input  wire                         wr_en,
    input  wire [31:0]                  wdata,
    output reg  [31:0]                  rdata,
    // fifo layout
    output wire [NUM*`IFS_MEM_AW-1:0]   start_addr,
    output wire [NUM*`IFS_MEM_AW-1:0]   end_addr,
    output wire [NUM*`IFS_SIZE_W-1:0]   size_quadlets
);

    wire [NUM*`IFS_IDX_W-1:0] first_all;
    wire [NUM*`IFS_IDX_W-1:0] last_all;
    wire [NUM-1:0]           hit;
    integer                  k;

    function [`IFS_PTR_W-1:0] ofs_of;
        input integer i;
        begin
            case (i)
                0: ofs_of = `IFS_OFS_RX_RSP;
                1: ofs_of = `IFS_OFS_RX_REQ;
                2: ofs_of = `IFS_OFS_TX_RSP;
                3: ofs_of = `IFS_OFS_TX_REQ;
                4: ofs_of = `IFS_OFS_ISO_RX;
                default: ofs_of = `IFS_OFS_ISO_TX;
            endcase
        end
    endfunction

    function [31:0] rst_of;
        input integer i;
        begin
            case (i)
                0: rst_of = `IFS_RST_RX_RSP;
                1: rst_of = `IFS_RST_RX_REQ;
                2: rst_of = `IFS_RST_TX_RSP;
                3: rst_of = `IFS_RST_TX_REQ;
                4: rst_of = `IFS_RST_ISO_RX;
                default: rst_of = `IFS_RST_ISO_TX;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // per fifo storage and layout
    // --------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM; g = g + 1) begin : g_fifo
            localparam [31:0] RST = rst_of(g);
            reg  [`IFS_IDX_W-1:0] fst_r;
            reg  [`IFS_IDX_W-1:0] lst_r;
            wire [`IFS_IDX_W:0]   nblk;

            assign hit[g] = (ptr == ofs_of(g));
            assign first_all[g*`IFS_IDX_W +: `IFS_IDX_W] = fst_r;
            assign last_all[g*`IFS_IDX_W +: `IFS_IDX_W]  = lst_r;

            // one process owns each fifo's fields; unused bits are never stored
            always @(posedge mclk) begin
                if (!rst_n) begin
                    fst_r <= RST[`IFS_FIRST_MSB:`IFS_FIRST_LSB];
                    lst_r <= RST[`IFS_LAST_MSB:`IFS_LAST_LSB];
                end else if (wr_en && hit[g]) begin
                    fst_r <= wdata[`IFS_FIRST_MSB:`IFS_FIRST_LSB];
                    lst_r <= wdata[`IFS_LAST_MSB:`IFS_LAST_LSB];
                end
            end

            // no check that last is above first; software owns that
            assign nblk = {1'b0, lst_r} - {1'b0, fst_r} + 7'h01;
            assign size_quadlets[g*`IFS_SIZE_W +: `IFS_SIZE_W] =
                {nblk, `IFS_BLOCK_LOW_ZERO};
            assign start_addr[g*`IFS_MEM_AW +: `IFS_MEM_AW] = {fst_r, `IFS_BLOCK_LOW_ZERO};
            assign end_addr[g*`IFS_MEM_AW +: `IFS_MEM_AW]   = {lst_r, `IFS_BLOCK_LOW_ONES};
        end
    endgenerate

    // --------------------------------------------------------------
    // read mux, unused bits and misses read zero
    // --------------------------------------------------------------
    always @* begin
        rdata = 32'h00000000;
        for (k = 0; k < NUM; k = k + 1) begin
            if (hit[k]) begin
                rdata = {18'h00000, first_all[k*`IFS_IDX_W +: `IFS_IDX_W], 2'b00,
                         last_all[k*`IFS_IDX_W +: `IFS_IDX_W]};
            end
        end
    end

endmodule

// File: rtl/ifs_indirect_regs.v
// host side indirect pointer/window, shadow register, fifo size bank
// assumes host pins are asynchronous and held stable during a strobe
`timescale 1ns/1ps
`include "ifs_map.vh"
module ifs_indirect_regs #(
    parameter NUM = `IFS_NUM_FIFOS
) (
    // clock and reset
    input  wire                          mclk,
    input  wire                          rst_n,
    // host strobes, active low pins
    input  wire                          host_cs_n,
    input  wire                          host_rd_n,
    input  wire                          host_wr_n,
    // host address and data pins
    input  wire                          register_select_line,
    input  wire [`IFS_HOST_AW-1:0]       host_addr,
    input  wire [3:0]                    host_be,
    input  wire [31:0]                   host_wdata,
    output reg  [31:0]                   host_rdata,
    output reg                           host_data_oe,
    output reg                           host_ack,
    // state visible to the rest of the link
    output wire [`IFS_PTR_W-1:0]         indirect_pointer,
    output wire [NUM*`IFS_MEM_AW-1:0]    fifo_start_addr,
    output wire [NUM*`IFS_MEM_AW-1:0]    fifo_end_addr,
    output wire [NUM*`IFS_SIZE_W-1:0]    fifo_size_quadlets
);

    localparam SW = 3 + 1 + 4 + `IFS_HOST_AW + 32;

    // --------------------------------------------------------------
    // pin synchronisation
    // --------------------------------------------------------------
    wire [SW-1:0]              pins_sync;
    wire                       s_cs_n;
    wire                       s_rd_n;
    wire                       s_wr_n;
    wire                       s_sel;
    wire [3:0]                 s_be;
    wire [`IFS_HOST_AW-1:0]    s_addr;
    wire [31:0]                s_wdata;

    ifs_sync #(
        .W (SW)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .pin_in   ({host_cs_n, host_rd_n, host_wr_n, register_select_line,
                    host_be, host_addr, host_wdata}),
        .rst_val  ({SW{1'b1}}),
        .pin_sync (pins_sync)
    );

    // data pins are sampled only after two stages, alongside strobes
    assign {s_cs_n, s_rd_n, s_wr_n, s_sel, s_be, s_addr, s_wdata} = pins_sync;

    // --------------------------------------------------------------
    // strobe edge detection
    // --------------------------------------------------------------
    reg  rd_prev_r;
    reg  wr_prev_r;
    wire rd_act;
    wire wr_act;
    wire rd_start;
    wire wr_start;

    assign rd_act   = !s_cs_n && !s_rd_n;
    assign wr_act   = !s_cs_n && !s_wr_n;
    // one access per strobe, however long the host holds it
    assign rd_start = rd_act && !rd_prev_r;
    assign wr_start = wr_act && !wr_prev_r && !rd_act;

    always @(posedge mclk) begin
        if (!rst_n) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end else begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
        end
    end

    // --------------------------------------------------------------
    // address decode of the direct register offsets
    // --------------------------------------------------------------
    reg  hit_shadow;
    reg  hit_pointer;
    reg  hit_window;

    always @* begin
        hit_shadow  = 1'b0;
        hit_pointer = 1'b0;
        hit_window  = 1'b0;
        if (!s_sel) begin
            hit_shadow = 1'b1;
        end else if (s_addr == `IFS_DIR_POINTER) begin
            hit_pointer = 1'b1;
        end else if (s_addr == `IFS_DIR_WINDOW) begin
            hit_window = 1'b1;
        end
    end

    // size registers have no direct offset at all

    // --------------------------------------------------------------
    // shadow register and byte merge
    // --------------------------------------------------------------
    reg  [31:0] shadow_r;
    reg  [31:0] shadow_nxt;
    wire [31:0] merged;

    // narrow hosts assemble a quadlet: untouched lanes come from shadow
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_lane
            assign merged[b*8 +: 8] = s_be[b] ? s_wdata[b*8 +: 8] : shadow_r[b*8 +: 8];
        end
    endgenerate

    always @* begin
        shadow_nxt = shadow_r;
        if (wr_start && hit_shadow) begin
            shadow_nxt = merged;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            shadow_r <= `IFS_SHADOW_RESET;
        end else begin
            shadow_r <= shadow_nxt;
        end
    end

    // --------------------------------------------------------------
    // indirect pointer
    // --------------------------------------------------------------
    reg  [`IFS_PTR_W-1:0] ptr_r;
    reg  [`IFS_PTR_W-1:0] ptr_nxt;
    wire                  win_access;

    assign win_access = (rd_start || wr_start) && hit_window;

    // pointer wraps at 16 bits; a wrap lands in reserved space
    always @* begin
        ptr_nxt = ptr_r;
        if (wr_start && hit_pointer) begin
            ptr_nxt = merged[`IFS_PTR_W-1:0];
        end else if (win_access) begin
            ptr_nxt = ptr_r + `IFS_QUADLET_STEP;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            ptr_r <= {`IFS_PTR_W{1'b0}};
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign indirect_pointer = ptr_r;

    // --------------------------------------------------------------
    // indirect space decode and size bank
    // --------------------------------------------------------------
    wire        in_size_range;
    wire [31:0] bank_rdata;

    // only the size window is live; everything else is reserved
    assign in_size_range = (ptr_r >= `IFS_SIZE_LO) && (ptr_r <= `IFS_SIZE_HI);

    ifs_size_bank #(
        .NUM (NUM)
    ) u_bank (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .ptr           (ptr_r),
        .wr_en         (wr_start && hit_window && in_size_range),
        .wdata         (merged),
        .rdata         (bank_rdata),
        .start_addr    (fifo_start_addr),
        .end_addr      (fifo_end_addr),
        .size_quadlets (fifo_size_quadlets)
    );

    // --------------------------------------------------------------
    // read data selection
    // --------------------------------------------------------------
    reg [31:0] rd_sel;

    always @* begin
        rd_sel = 32'h00000000;
        if (hit_shadow) begin
            rd_sel = shadow_r;
        end else if (hit_pointer) begin
            rd_sel = {16'h0000, ptr_r};
        end else if (hit_window && in_size_range) begin
            rd_sel = bank_rdata;
        end
    end

    // --------------------------------------------------------------
    // host answer: data, drive enable and acknowledge
    // --------------------------------------------------------------
    // data is held until the next read so a slow host can sample it
    always @(posedge mclk) begin
        if (!rst_n) begin
            host_rdata   <= 32'h00000000;
            host_data_oe <= 1'b0;
            host_ack     <= 1'b0;
        end else begin
            host_ack <= rd_start || wr_start;
            if (rd_start) begin
                host_rdata   <= rd_sel;
                host_data_oe <= 1'b1;
            end else if (!rd_act) begin
                host_data_oe <= 1'b0;
            end
        end
    end

endmodule

// File: tb/ifs_chk.sv
// assertions on the ports of the indirect fifo size register bank
// assumes the host holds pins from two cycles before a strobe until ack
`timescale 1ns/1ps
`include "ifs_map.vh"
module ifs_chk #(
    parameter NUM = `IFS_NUM_FIFOS
) (
    // clock and reset
    input wire                        mclk,
    input wire                        rst_n,
    // host pins
    input wire                        host_cs_n,
    input wire                        host_rd_n,
    input wire                        host_wr_n,
    input wire                        register_select_line,
    input wire [`IFS_HOST_AW-1:0]     host_addr,
    input wire [3:0]                  host_be,
    input wire [31:0]                 host_wdata,
    input wire [31:0]                 host_rdata,
    input wire                        host_data_oe,
    input wire                        host_ack,
    // link side state
    input wire [`IFS_PTR_W-1:0]       indirect_pointer,
    input wire [NUM*`IFS_MEM_AW-1:0]  fifo_start_addr,
    input wire [NUM*`IFS_MEM_AW-1:0]  fifo_end_addr,
    input wire [NUM*`IFS_SIZE_W-1:0]  fifo_size_quadlets
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // --------------------------------------------------------------
    // access steps
    // --------------------------------------------------------------
    sequence s_quiet;
        !host_ack [*4];
    endsequence
    sequence s_win_sel;
        host_ack && register_select_line && host_addr == 8'hfc;
    endsequence
    AST_ANSWER: assert property ($fell(host_cs_n) |-> ##[2:5] host_ack)
        else $error("no ack after strobe");
    AST_ONE_ACK: assert property (host_ack |=> s_quiet)
        else $error("ack not a single pulse per access");
    AST_PTR_STEP: assert property (s_win_sel |-> indirect_pointer == $past(indirect_pointer) + 16'h0004)
        else $error("window access did not step pointer");
    AST_PTR_WRITE: assert property (host_ack && !host_wr_n && host_rd_n && register_select_line
        && host_addr == 8'hf8 && host_be == 4'hf |-> indirect_pointer == host_wdata[15:0])
        else $error("pointer write lost");
    AST_PTR_CAUSE: assert property ($changed(indirect_pointer) |-> host_ack)
        else $error("pointer moved without access");
    AST_SHADOW: assert property (host_ack && !register_select_line |-> $stable(indirect_pointer))
        else $error("select low access touched pointer");
    AST_OE_READ: assert property ($rose(host_data_oe) |-> host_ack && !host_rd_n)
        else $error("data driven outside a read");
    AST_LAYOUT: assert property ($changed(fifo_start_addr) || $changed(fifo_end_addr) |->
        host_ack && !host_wr_n && register_select_line && host_addr == 8'hfc)
        else $error("layout changed without window write");
    AST_SIZE: assert property (fifo_size_quadlets[12:0] == {({1'b0, fifo_end_addr[11:6]}
        - {1'b0, fifo_start_addr[11:6]} + 7'h01), 6'h00})
        else $error("size does not follow block indices");
    AST_BLOCK_ENDS: assert property (fifo_start_addr[5:0] == 6'h00 && fifo_end_addr[5:0] == 6'h3f)
        else $error("block low bits wrong");
    AST_SIZE_RXREQ: assert property (fifo_size_quadlets[25:13] == {({1'b0, fifo_end_addr[23:18]}
        - {1'b0, fifo_start_addr[23:18]} + 7'h01), 6'h00})
        else $error("rx request size does not follow block indices");
    AST_OE_DROP: assert property ($rose(host_rd_n) |-> ##[1:4] !host_data_oe)
        else $error("data still driven after read");
endmodule
bind ifs_indirect_regs ifs_chk #(.NUM(NUM)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .register_select_line(register_select_line), .host_addr(host_addr), .host_be(host_be),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_data_oe(host_data_oe),
    .host_ack(host_ack), .indirect_pointer(indirect_pointer),
    .fifo_start_addr(fifo_start_addr), .fifo_end_addr(fifo_end_addr),
    .fifo_size_quadlets(fifo_size_quadlets));

// File: tb/ifs_host_bfm.sv
// host processor model driving the parallel host pins
// assumes one clock shared with the device; waits on ack, bounded
`timescale 1ns/1ps
module ifs_host_bfm (
    // clock and answer
    input  wire         mclk,
    input  wire         host_ack,
    input  wire [31:0]  host_rdata,
    // pins driven by the host
    output logic        host_cs_n,
    output logic        host_rd_n,
    output logic        host_wr_n,
    output logic        register_select_line,
    output logic [7:0]  host_addr,
    output logic [3:0]  host_be,
    output logic [31:0] host_wdata
);
    // accesses that never saw ack, folded into the bench verdict
    int acc_timeouts = 0;
    // idle pins at time zero, strobes inactive
    initial begin
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        register_select_line = 1'b0;
        host_addr = 8'h00;
        host_be = 4'h0;
        host_wdata = 32'h00000000;
    end
    // one access; pins settle two cycles ahead since the device syncs them
    task automatic acc(input logic rd, sel, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] q);
        int n;
        begin
            @(posedge mclk);
            register_select_line <= sel;
            host_addr <= a;
            host_be <= be;
            host_wdata <= wd;
            repeat (2) @(posedge mclk);
            host_cs_n <= 1'b0;
            if (rd) host_rd_n <= 1'b0;
            else host_wr_n <= 1'b0;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (host_ack !== 1'b1 && n < 20);
            if (host_ack !== 1'b1) begin
                acc_timeouts++;
                $display("[ERR] host_ack exp=1 seen=%b", host_ack);
            end
            q = host_rdata;
            {host_cs_n, host_rd_n, host_wr_n} <= 3'h7;
            // released address and data lines show garbage, not the last value
            host_addr <= ~a;
            host_wdata <= ~wd;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the indirect fifo size register bank
// assumes the host model and the bound checker beside the design
`timescale 1ns/1ps
module tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    wire         cs_n, rd_n, wr_n, sel, oe, ack;
    wire [7:0]   addr;
    wire [3:0]   be;
    wire [31:0]  wdata, rdata;
    wire [15:0]  ptr;
    wire [71:0]  st, en;
    wire [77:0]  sz;
    logic [31:0] q;
    int          mismatches = 0;
    int          checked = 0;
    // 25 MHz clock
    always #20 mclk = ~mclk;
    ifs_host_bfm u_host (.mclk(mclk), .host_ack(ack), .host_rdata(rdata),
        .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .register_select_line(sel),
        .host_addr(addr), .host_be(be), .host_wdata(wdata));
    ifs_indirect_regs u_dut (.mclk(mclk), .rst_n(rst_n), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .register_select_line(sel), .host_addr(addr), .host_be(be),
        .host_wdata(wdata), .host_rdata(rdata), .host_data_oe(oe), .host_ack(ack),
        .indirect_pointer(ptr), .fifo_start_addr(st), .fifo_end_addr(en),
        .fifo_size_quadlets(sz));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic s, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        u_host.acc(1'b0, s, a, 4'hf, d, unused);
    endtask
    task automatic rd(input logic s, input logic [7:0] a);
        u_host.acc(1'b1, s, a, 4'h0, 32'h0, q);
    endtask
    // reset contents of the indirect space, zero where reserved
    function automatic logic [31:0] rv(input logic [15:0] a);
        case (a)
            16'h0100: rv = 32'h00000003;
            16'h0104: rv = 32'h00000407;
            16'h0110: rv = 32'h0000080b;
            16'h0114: rv = 32'h00000c0f;
            16'h0120: rv = 32'h0000101f;
            16'h0130: rv = 32'h0000202f;
            default:  rv = 32'h00000000;
        endcase
    endfunction
    task automatic print_verdict;
        mismatches += u_host.acc_timeouts;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: whole run needs well under 1500 cycles
    initial begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        $display("[ERR] watchdog exp=done seen=hang");
        print_verdict;
    end
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(1'b0, 8'hfc); chk("shadow", q, 32'h0f0a0500);
        wr(1'b1, 8'hf8, 32'h00000100);
        for (int i = 0; i < 13; i++) begin
            rd(1'b1, 8'hfc); chk("size", q, rv(16'h0100 + 16'(4 * i)));
        end
        rd(1'b1, 8'hf8); chk("ptr", q, 32'h00000134);
        // unused bits dropped; last kept above first
        wr(1'b1, 8'hf8, 32'h00000104);
        wr(1'b1, 8'hfc, 32'hffffc0fe);
        wr(1'b1, 8'hfc, 32'hffffffff);
        chk("ptr", {16'h0, ptr}, 32'h0000010c);
        wr(1'b1, 8'hf8, 32'h00000104);
        rd(1'b1, 8'hfc); chk("rxreq", q, 32'h0000003e);
        rd(1'b1, 8'hfc); chk("resv", q, 32'h00000000);
        chk("start", {20'h0, st[23:12]}, 32'h00000000);
        chk("end", {20'h0, en[23:12]}, 32'h00000fbf);
        chk("quad", {19'h0, sz[25:13]}, 32'h00000fc0);
        wr(1'b1, 8'hf8, 32'h00000130);
        wr(1'b1, 8'hfc, 32'h00000a1e);
        chk("start", {20'h0, st[71:60]}, 32'h00000280);
        chk("quad", {19'h0, sz[77:65]}, 32'h00000540);
        // select low goes to shadow only; pointer then takes shadow lanes
        wr(1'b0, 8'hfc, 32'h0000fffc);
        chk("ptr", {16'h0, ptr}, 32'h00000134);
        chk("quad", {19'h0, sz[77:65]}, 32'h00000540);
        u_host.acc(1'b0, 1'b1, 8'hf8, 4'h0, 32'h00000000, q);
        chk("ptr", {16'h0, ptr}, 32'h0000fffc);
        rd(1'b1, 8'hfc); chk("resv", q, 32'h00000000);
        chk("wrap", {16'h0, ptr}, 32'h00000000);
        // direct offsets other than the pair reach nothing
        wr(1'b1, 8'h00, 32'hffffffff);
        rd(1'b1, 8'h00); chk("direct", q, 32'h00000000);
        chk("ptr", {16'h0, ptr}, 32'h00000000);
        // second reset restores the default partition
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        wr(1'b1, 8'hf8, 32'h00000130);
        rd(1'b1, 8'hfc); chk("isotx", q, 32'h0000202f);
        print_verdict;
    end
endmodule
